/* File: core/vhz_pkg.sv */
package vhz_pkg;
  // Bus geometry and answers
  localparam int          ADDR_W      = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0]  OFS_DELAY_TYPE  = 8'h00;
  localparam logic [7:0]  OFS_TIME_MULT   = 8'h04;
  localparam logic [7:0]  OFS_DEF_DELAY   = 8'h08;
  localparam logic [7:0]  OFS_ALARM_DELAY = 8'h0C;
  localparam logic [7:0]  OFS_PICKUP_PCT  = 8'h10;
  localparam logic [7:0]  OFS_CURVE_EXP   = 8'h14;
  localparam logic [7:0]  OFS_STATUS      = 8'h18;
  localparam logic [7:0]  OFS_EXPECTED    = 8'h1C;
  localparam logic [7:0]  OFS_REMAIN      = 8'h20;
  localparam logic [7:0]  OFS_RATIO       = 8'h24;
  localparam logic [7:0]  OFS_NOMINAL     = 8'h28;
  // Status field positions
  localparam int ST_BLK_POS     = 0;
  localparam int ST_PICKUP_POS  = 1;
  localparam int ST_START_POS   = 2;
  localparam int ST_TRIP_POS    = 3;
  localparam int ST_BLOCKED_POS = 4;
  localparam int ST_ALARM_POS   = 5;
  // Setting limits, times in 5 ms steps
  localparam logic [12:0] MULT_MIN = 13'h0001;
  localparam logic [12:0] MULT_MAX = 13'h1964;
  localparam logic [18:0] TIME_MAX = 19'h57E40;
  // Reset values
  localparam logic [12:0] MULT_RST        = 13'h0001;
  localparam logic [18:0] DEF_DELAY_RST   = 19'h00008;
  localparam logic [18:0] ALARM_DELAY_RST = 19'h00008;
  localparam logic [13:0] PICKUP_PCT_RST  = 14'h01F4;
  localparam logic [3:0]  CURVE_EXP_RST   = 4'h1;
  // Fixed-point scaling
  localparam logic [31:0] MILLI     = 32'h000003E8;
  localparam logic [31:0] INV_GAIN  = 32'h00000168;
  localparam logic [31:0] PCT_UNITY = 32'h00002710;
  // Processing cycle timing
  localparam int unsigned TICK_TIME_US   = 5000;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned TICK_CYCLES    = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SEQ_MIN_CYCLES = 256;
  localparam logic [5:0]  DIV_STEPS      = 6'h20;
  localparam logic [3:0]  REL_TICKS      = 4'h1;

  typedef enum logic [1:0] {
    DLY_DEFINITE = 2'h0,
    DLY_INVERSE  = 2'h1,
    DLY_BOTH     = 2'h2
  } delay_type_t;

  typedef enum logic [5:0] {
    SEQ_IDLE  = 6'h01,
    SEQ_NOM   = 6'h02,
    SEQ_RATIO = 6'h04,
    SEQ_POW   = 6'h08,
    SEQ_INV   = 6'h10,
    SEQ_EVAL  = 6'h20
  } seq_t;

  typedef struct packed {
    logic [15:0] vhz_milli;
    logic [15:0] volt_pu_milli;
    logic [15:0] freq_milli;
  } meas_t;

  typedef struct packed {
    logic alarm;
    logic blocked;
    logic trip;
    logic start;
  } flags_t;

  typedef struct packed {
    delay_type_t dtype;
    logic [12:0] mult;
    logic [18:0] def_delay;
    logic [18:0] alarm_delay;
    logic [13:0] pickup_pct;
    logic [3:0]  curve_exp;
  } cfg_t;

  localparam cfg_t CFG_RST = '{dtype: DLY_DEFINITE, mult: MULT_RST, def_delay: DEF_DELAY_RST,
                               alarm_delay: ALARM_DELAY_RST, pickup_pct: PICKUP_PCT_RST,
                               curve_exp: CURVE_EXP_RST};

  typedef struct packed {
    cfg_t        cfg;
    seq_t        seq;
    logic [31:0] tick_cnt;
    logic [5:0]  div_cnt;
    logic [31:0] dv_n;
    logic [31:0] dv_d;
    logic [31:0] dv_r;
    logic [31:0] nom;
    logic [31:0] ratio;
    logic [31:0] pow;
    logic [3:0]  pow_cnt;
    logic [31:0] inv;
    logic        blk;
    logic        pickup;
    flags_t      flags;
    logic [18:0] op_time;
    logic [18:0] expected;
    logic [18:0] remain;
    logic [18:0] elapsed;
    logic [18:0] alarm_cnt;
    logic [3:0]  rel_cnt;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;
endpackage : vhz_pkg

/* File: core/overexcitation_stage.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Time multiplier 0.01 to 65.00 in 0.01 steps, default 0.01.
// - Multiplier used only in inverse or definite-plus-inverse delay types.
// - Definite delay 0 to 1800 s in 5 ms steps, default 40 ms.
// - Definite delay applies in full however far the ratio exceeds pick-up.
// - Inverse time is 0.18 k over excess to exponent; definite-plus-inverse adds the definite delay.
// - Expected operating time readable, 0 to 1800 s, 5 ms resolution.
// - While timing a fault, remaining time to trip counts down and reads back.
// - Measured over nominal volts-per-hertz reported with 0.001 resolution.
// - Nominal volts-per-hertz is per-unit voltage over nominal frequency.
// - Block input sampled once at the start of each processing cycle.
// - Pick-up with block inactive raises start and begins timing.
// - Pick-up with block active raises blocked and stops further timing.
// - Block after start clears start and runs release timing as drop-out.
// - Delay type selects definite, inverse, or definite-plus-inverse timing.
// - Pick-up when ratio exceeds nominal by set percentage, default 5.00.
// - Alarm raised after its own definite delay, default 40 ms.
module overexcitation_stage #(
  parameter int unsigned TICK_CYCLES = vhz_pkg::TICK_CYCLES
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [vhz_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [vhz_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire vhz_pkg::meas_t             meas,
  input  wire logic                       block_in,
  output vhz_pkg::flags_t                 flags
);
  vhz_pkg::state_t st_reg;
  vhz_pkg::state_t st_next;

  // Sequence must fit inside one processing cycle
  if (TICK_CYCLES < vhz_pkg::SEQ_MIN_CYCLES) begin : g_tick_chk
    $error("TICK_CYCLES too small for the evaluation sequence");
  end

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Clamp a delay setting to its range
  function automatic logic [18:0] clamp_time(input logic [31:0] v);
    return (v > 32'(vhz_pkg::TIME_MAX)) ? vhz_pkg::TIME_MAX : v[18:0];
  endfunction : clamp_time

  // Next-state logic of bus, sequencer and timers
  always_comb begin
    logic [32:0] rr;
    logic [63:0] prod;
    logic [63:0] pq;
    logic [31:0] excess;
    logic [31:0] wv;
    logic [19:0] op_sum;
    logic [18:0] inv_c;
    logic [18:0] op;
    logic [18:0] el;
    logic [35:0] lhs;
    logic        pick;
    rr      = '0;
    prod    = '0;
    pq      = '0;
    wv      = '0;
    st_next = st_reg;
    excess  = (st_reg.ratio > vhz_pkg::MILLI) ? st_reg.ratio - vhz_pkg::MILLI : 32'h00000000;
    inv_c   = clamp_time(st_reg.inv);
    op_sum  = 20'(st_reg.cfg.def_delay) + 20'(inv_c);
    case (st_reg.cfg.dtype)
      vhz_pkg::DLY_DEFINITE: op = st_reg.cfg.def_delay;
      vhz_pkg::DLY_INVERSE:  op = inv_c;
      default:               op = clamp_time(32'(op_sum));
    endcase
    lhs  = 36'(st_reg.ratio) * 36'h00000000A;
    pick = lhs > 36'(vhz_pkg::PCT_UNITY + 32'(st_reg.cfg.pickup_pct));
    el   = (st_reg.elapsed < vhz_pkg::TIME_MAX) ? st_reg.elapsed + 19'h00001 : st_reg.elapsed;

    // Shared restoring divider, quotient shifts into dv_n
    if (st_reg.div_cnt != 6'h00) begin
      rr = {st_reg.dv_r, st_reg.dv_n[31]};
      if (rr >= 33'(st_reg.dv_d)) begin
        rr = rr - 33'(st_reg.dv_d);
        st_next.dv_n = {st_reg.dv_n[30:0], 1'b1};
      end else begin
        st_next.dv_n = {st_reg.dv_n[30:0], 1'b0};
      end
      st_next.dv_r    = rr[31:0];
      st_next.div_cnt = st_reg.div_cnt - 6'h01;
    end

    if (st_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = 32'h00000000;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 32'h00000001;
    end

    case (st_reg.seq)
      vhz_pkg::SEQ_IDLE: begin
        if (st_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
          st_next.blk     = block_in;
          // nominal is per-unit voltage over frequency
          st_next.dv_n    = 32'(meas.volt_pu_milli) * vhz_pkg::MILLI;
          st_next.dv_d    = 32'(meas.freq_milli);
          st_next.dv_r    = 32'h00000000;
          st_next.div_cnt = vhz_pkg::DIV_STEPS;
          st_next.seq     = vhz_pkg::SEQ_NOM;
        end
      end
      vhz_pkg::SEQ_NOM: begin
        if (st_reg.div_cnt == 6'h00) begin
          st_next.nom     = st_reg.dv_n;
          st_next.dv_n    = 32'(meas.vhz_milli) * vhz_pkg::MILLI;
          st_next.dv_d    = st_reg.dv_n;
          st_next.dv_r    = 32'h00000000;
          st_next.div_cnt = vhz_pkg::DIV_STEPS;
          st_next.seq     = vhz_pkg::SEQ_RATIO;
        end
      end
      vhz_pkg::SEQ_RATIO: begin
        if (st_reg.div_cnt == 6'h00) begin
          st_next.ratio   = st_reg.dv_n;
          st_next.pow     = vhz_pkg::MILLI;
          st_next.pow_cnt = st_reg.cfg.curve_exp;
          st_next.seq     = vhz_pkg::SEQ_POW;
        end
      end
      vhz_pkg::SEQ_POW: begin
        // excess raised to the exponent, milli scale
        if (st_reg.pow_cnt != 4'h0) begin
          prod            = 64'(st_reg.pow) * 64'(excess);
          pq              = prod / 64'(vhz_pkg::MILLI);
          st_next.pow     = (pq[63:32] != 32'h00000000) ? 32'hFFFFFFFF : pq[31:0];
          st_next.pow_cnt = st_reg.pow_cnt - 4'h1;
        end else begin
          // 0.18 k term in 5 ms steps
          st_next.dv_n    = 32'(st_reg.cfg.mult) * vhz_pkg::INV_GAIN;
          st_next.dv_d    = st_reg.pow;
          st_next.dv_r    = 32'h00000000;
          st_next.div_cnt = vhz_pkg::DIV_STEPS;
          st_next.seq     = vhz_pkg::SEQ_INV;
        end
      end
      vhz_pkg::SEQ_INV: begin
        if (st_reg.div_cnt == 6'h00) begin
          st_next.inv = st_reg.dv_n;
          st_next.seq = vhz_pkg::SEQ_EVAL;
        end
      end
      vhz_pkg::SEQ_EVAL: begin
        st_next.seq    = vhz_pkg::SEQ_IDLE;
        st_next.pickup = pick;
        if (pick && !st_reg.blk) begin
          if (st_reg.alarm_cnt >= st_reg.cfg.alarm_delay) begin
            st_next.flags.alarm = 1'b1;
          end else begin
            st_next.alarm_cnt = st_reg.alarm_cnt + 19'h00001;
          end
        end else begin
          st_next.alarm_cnt   = 19'h00000;
          st_next.flags.alarm = 1'b0;
        end
        if (st_reg.flags.start) begin
          if (!pick || st_reg.blk) begin
            // block after start acts as drop-out
            st_next.flags.start = 1'b0;
            st_next.rel_cnt     = vhz_pkg::REL_TICKS;
            st_next.elapsed     = 19'h00000;
            st_next.remain      = 19'h00000;
          end else begin
            st_next.elapsed  = el;
            st_next.op_time  = op;
            st_next.expected = op;
            st_next.remain   = (op > el) ? op - el : 19'h00000;
            if (op <= el) begin
              st_next.flags.trip = 1'b1;
            end
          end
        end else begin
          // Release timing holds trip, then drops it
          if (st_reg.rel_cnt != 4'h0) begin
            st_next.rel_cnt = st_reg.rel_cnt - 4'h1;
          end else begin
            st_next.flags.trip = 1'b0;
          end
          st_next.flags.blocked = pick && st_reg.blk;
          if (pick && !st_reg.blk) begin
            st_next.flags.start = 1'b1;
            st_next.elapsed     = 19'h00000;
            st_next.op_time     = op;
            st_next.expected    = op;
            st_next.remain      = op;
            st_next.flags.trip  = st_reg.flags.trip || (op == 19'h00000);
          end
        end
      end
      default: st_next.seq = vhz_pkg::SEQ_IDLE;
    endcase

    // Write address and data channels, either order
    if (awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata  = wdata;
      st_next.wstrb  = wstrb;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_next.aw_have && st_next.w_have && !st_next.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = vhz_pkg::RESP_OKAY;
      case (st_next.aw_addr)
        vhz_pkg::OFS_DELAY_TYPE: begin
          wv = merge(32'(st_reg.cfg.dtype), st_next.wdata, st_next.wstrb);
          if (wv[1:0] != 2'h3) begin
            st_next.cfg.dtype = vhz_pkg::delay_type_t'(wv[1:0]);
          end
        end
        vhz_pkg::OFS_TIME_MULT: begin
          wv = merge(32'(st_reg.cfg.mult), st_next.wdata, st_next.wstrb);
          st_next.cfg.mult = (wv < 32'(vhz_pkg::MULT_MIN)) ? vhz_pkg::MULT_MIN :
                             (wv > 32'(vhz_pkg::MULT_MAX)) ? vhz_pkg::MULT_MAX : wv[12:0];
        end
        vhz_pkg::OFS_DEF_DELAY: begin
          // definite delay clamped to its range
          wv = merge(32'(st_reg.cfg.def_delay), st_next.wdata, st_next.wstrb);
          st_next.cfg.def_delay = clamp_time(wv);
        end
        vhz_pkg::OFS_ALARM_DELAY: begin
          wv = merge(32'(st_reg.cfg.alarm_delay), st_next.wdata, st_next.wstrb);
          st_next.cfg.alarm_delay = clamp_time(wv);
        end
        vhz_pkg::OFS_PICKUP_PCT: begin
          wv = merge(32'(st_reg.cfg.pickup_pct), st_next.wdata, st_next.wstrb);
          st_next.cfg.pickup_pct = wv[13:0];
        end
        vhz_pkg::OFS_CURVE_EXP: begin
          wv = merge(32'(st_reg.cfg.curve_exp), st_next.wdata, st_next.wstrb);
          st_next.cfg.curve_exp = wv[3:0];
        end
        vhz_pkg::OFS_STATUS, vhz_pkg::OFS_EXPECTED, vhz_pkg::OFS_REMAIN,
        vhz_pkg::OFS_RATIO, vhz_pkg::OFS_NOMINAL: st_next.bresp = vhz_pkg::RESP_OKAY;
        default: st_next.bresp = vhz_pkg::RESP_SLVERR;
      endcase
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;

    // Read channel, one beat after the address
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = vhz_pkg::RESP_OKAY;
      case (araddr)
        vhz_pkg::OFS_DELAY_TYPE:  st_next.rdata = 32'(st_reg.cfg.dtype);
        vhz_pkg::OFS_TIME_MULT:   st_next.rdata = 32'(st_reg.cfg.mult);
        vhz_pkg::OFS_DEF_DELAY:   st_next.rdata = 32'(st_reg.cfg.def_delay);
        vhz_pkg::OFS_ALARM_DELAY: st_next.rdata = 32'(st_reg.cfg.alarm_delay);
        vhz_pkg::OFS_PICKUP_PCT:  st_next.rdata = 32'(st_reg.cfg.pickup_pct);
        vhz_pkg::OFS_CURVE_EXP:   st_next.rdata = 32'(st_reg.cfg.curve_exp);
        vhz_pkg::OFS_STATUS: begin
          st_next.rdata = 32'h00000000;
          st_next.rdata[vhz_pkg::ST_BLK_POS]     = st_reg.blk;
          st_next.rdata[vhz_pkg::ST_PICKUP_POS]  = st_reg.pickup;
          st_next.rdata[vhz_pkg::ST_START_POS]   = st_reg.flags.start;
          st_next.rdata[vhz_pkg::ST_TRIP_POS]    = st_reg.flags.trip;
          st_next.rdata[vhz_pkg::ST_BLOCKED_POS] = st_reg.flags.blocked;
          st_next.rdata[vhz_pkg::ST_ALARM_POS]   = st_reg.flags.alarm;
        end
        vhz_pkg::OFS_EXPECTED:    st_next.rdata = 32'(st_reg.expected);
        vhz_pkg::OFS_REMAIN:      st_next.rdata = 32'(st_reg.remain);
        vhz_pkg::OFS_RATIO:       st_next.rdata = st_reg.ratio;
        vhz_pkg::OFS_NOMINAL:     st_next.rdata = st_reg.nom;
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = vhz_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // Synchronous reset
    if (!aresetn) begin
      st_next     = '0;
      st_next.cfg = vhz_pkg::CFG_RST;
      st_next.seq = vhz_pkg::SEQ_IDLE;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  // Outputs straight from flops
  assign awready = st_reg.awready;
  assign wready  = st_reg.wready;
  assign bvalid  = st_reg.bvalid;
  assign bresp   = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid  = st_reg.rvalid;
  assign rdata   = st_reg.rdata;
  assign rresp   = st_reg.rresp;
  assign flags   = st_reg.flags;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  blocked_no_start_a: assert property ($rose(flags.blocked) |-> !flags.start && st_reg.blk)
    else $error("blocked raised without block or with start");
  start_cause_a: assert property ($rose(flags.start) |-> st_reg.pickup && !st_reg.blk)
    else $error("start raised without clean pick-up");
  trip_at_zero_a: assert property ($rose(flags.trip) |-> flags.start && st_reg.remain == 19'h0)
    else $error("trip raised before remaining time reached zero");
  remain_count_a: assert property (flags.start |->
      st_reg.remain == ((st_reg.op_time > st_reg.elapsed) ? st_reg.op_time - st_reg.elapsed : 19'h0))
    else $error("remaining time does not match elapsed count");
  release_block_a: assert property ((st_reg.seq == vhz_pkg::SEQ_EVAL && flags.start
      && st_reg.blk) |=> !flags.start && st_reg.remain == 19'h0)
    else $error("start not cleared on late block");
  definite_full_a: assert property ((st_reg.seq == vhz_pkg::SEQ_EVAL && !flags.start &&
      st_reg.cfg.dtype == vhz_pkg::DLY_DEFINITE) |=> st_reg.op_time == $past(st_reg.cfg.def_delay)
      || !flags.start)
    else $error("definite delay not applied in full");
  block_sample_a: assert property ((st_reg.seq == vhz_pkg::SEQ_IDLE &&
      st_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) |=> st_reg.blk == $past(block_in))
    else $error("block input not sampled at cycle start");
  ratio_store_a: assert property ((st_reg.seq == vhz_pkg::SEQ_RATIO &&
      st_reg.div_cnt == 6'h00) |=> st_reg.ratio == $past(st_reg.dv_n))
    else $error("ratio not taken from divider");
  write_resp_a: assert property ((awvalid && awready && wvalid && wready) |=> bvalid)
    else $error("write response missing");
  read_resp_a: assert property ((arvalid && arready) |=> rvalid ##0 !arready)
    else $error("read data missing");

  start_seen_c: cover property ($rose(flags.start));
  trip_seen_c: cover property ($rose(flags.trip));
  blocked_seen_c: cover property ($rose(flags.blocked));
  late_block_c: cover property (flags.start ##1 !flags.start && st_reg.blk);
endmodule : overexcitation_stage
`default_nettype wire

/* File: bench/vhz_front_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vhz_front_model (
  input  wire logic     fault,
  input  wire logic     blk_req,
  output vhz_pkg::meas_t meas,
  output logic          block_in
);
  // 1.0 pu at 50 Hz; ratio 1.10 while faulted, 1.00 otherwise
  assign meas.volt_pu_milli = 16'h03E8;
  assign meas.freq_milli = 16'hC350;
  assign meas.vhz_milli = fault ? 16'h0016 : 16'h0014;
  assign block_in = blk_req;
endmodule : vhz_front_model
`default_nettype wire

/* File: bench/overexcitation_stage_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module overexcitation_stage_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, fault = 0, blk_req = 0;
  logic awready, wready, bvalid, arready, rvalid, block_in;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  vhz_pkg::meas_t meas;
  vhz_pkg::flags_t flags;
  int fail_count = 0, checks_done = 0, cyc = 0, t0;
  overexcitation_stage #(.TICK_CYCLES(300)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas(meas),
    .block_in(block_in), .flags(flags));
  vhz_front_model front_u (.fault(fault), .blk_req(blk_req), .meas(meas), .block_in(block_in));
  always #2 aclk = ~aclk;
  // Cycle count and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write: address and data offered together, bready held until answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = vhz_pkg::RESP_OKAY);
    logic [1:0] r;
    r = 2'h0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp; bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr
  // Read and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0;
      end
    end while (arvalid || rready);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rc
  task automatic wait_flag(input int p, input logic v);
    int n;
    n = 0;
    while (flags[p] !== v && n < 1500) begin
      @(posedge aclk);
      n++;
    end
    chk("flag wait", 32'h0, (n == 1500) ? 32'h1 : 32'h0);
  endtask : wait_flag
  task automatic quiet();
    fault <= 1'b0; blk_req <= 1'b0;
    repeat (1200) @(posedge aclk);
  endtask : quiet
  task automatic t_regs();
    rc(vhz_pkg::OFS_DELAY_TYPE, 32'h0, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_TIME_MULT, 32'h1, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_DEF_DELAY, 32'h8, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_ALARM_DELAY, 32'h8, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_PICKUP_PCT, 32'h1F4, vhz_pkg::RESP_OKAY);
    wr(vhz_pkg::OFS_TIME_MULT, 32'h1B58);
    rc(vhz_pkg::OFS_TIME_MULT, 32'h1964, vhz_pkg::RESP_OKAY);
    wr(vhz_pkg::OFS_DEF_DELAY, 32'h60000);
    rc(vhz_pkg::OFS_DEF_DELAY, 32'h57E40, vhz_pkg::RESP_OKAY);
    rc(8'h30, 32'h0, vhz_pkg::RESP_SLVERR);
    wr(8'h30, 32'h0, vhz_pkg::RESP_SLVERR);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes();
    logic [31:0] ev [3] = '{32'h2, 32'h168, 32'h16A};
    wr(vhz_pkg::OFS_TIME_MULT, 32'h64);
    wr(vhz_pkg::OFS_DEF_DELAY, 32'h2);
    for (int i = 0; i < 3; i++) begin
      wr(vhz_pkg::OFS_DELAY_TYPE, i);
      fault <= 1'b1;
      wait_flag(0, 1'b1);
      rc(vhz_pkg::OFS_EXPECTED, ev[i], vhz_pkg::RESP_OKAY);
      quiet();
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_trip();
    wr(vhz_pkg::OFS_DELAY_TYPE, 32'h0);
    wr(vhz_pkg::OFS_ALARM_DELAY, 32'h3);
    fault <= 1'b1;
    wait_flag(0, 1'b1);
    t0 = cyc;
    rc(vhz_pkg::OFS_REMAIN, 32'h2, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_RATIO, 32'h44C, vhz_pkg::RESP_OKAY);
    rc(vhz_pkg::OFS_NOMINAL, 32'h14, vhz_pkg::RESP_OKAY);
    wait_flag(1, 1'b1);
    chk("trip time", 32'd600, cyc - t0);
    wait_flag(3, 1'b1);
    chk("alarm time", 32'd900, cyc - t0);
    quiet();
    $display("test trip done");
  endtask : t_trip
  task automatic t_block();
    blk_req <= 1'b1;
    repeat (600) @(posedge aclk);
    fault <= 1'b1;
    wait_flag(2, 1'b1);
    chk("start", 32'h0, {31'h0, flags.start});
    rc(vhz_pkg::OFS_STATUS, 32'h13, vhz_pkg::RESP_OKAY);
    quiet();
    wr(vhz_pkg::OFS_DEF_DELAY, 32'h4);
    fault <= 1'b1;
    wait_flag(0, 1'b1);
    blk_req <= 1'b1;
    wait_flag(0, 1'b0);
    chk("trip", 32'h0, {31'h0, flags.trip});
    quiet();
    $display("test block done");
  endtask : t_block
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_modes();
    t_trip();
    t_block();
    close_out();
  end
endmodule : overexcitation_stage_tb_top
`default_nettype wire
